/* File: opc_regs.svh */
/*
 * Register offsets, field positions, reset values and timing counts for
 * the port control register bank.
 * Assumes a 250 MHz core clock and byte addressing on the register bus.
 */
`ifndef OPC_REGS_SVH
`define OPC_REGS_SVH

// ---------------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------------
`define OPC_OFS_CTRL        16'hc098
`define OPC_OFS_IRQ_STATUS  16'hc09c
`define OPC_OFS_IRQ_MASK    16'hc0a0
`define OPC_ADDR_W          16

// ---------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------
`define OPC_BIT_VBUS_PU     13
`define OPC_BIT_RX_OFF      12
`define OPC_BIT_PUMP        11
`define OPC_BIT_VBUS_DIS    10
`define OPC_BIT_DP_PU       9
`define OPC_BIT_DM_PU       8
`define OPC_BIT_DP_PD       7
`define OPC_BIT_DM_PD       6
`define OPC_BIT_VBUS_LVL    2
`define OPC_BIT_ID          1
`define OPC_BIT_VBUS_OK     0
`define OPC_CTRL_MASK       16'h3fc0
`define OPC_STAT_MASK       16'h0007
`define OPC_IRQ_MASK_BITS   16'h0007

// ---------------------------------------------------------------------
// Reset values and timing
// ---------------------------------------------------------------------
`define OPC_CTRL_RESET      16'h0000
`define OPC_IRQ_RESET       16'h0000
`define OPC_CLK_MHZ         250
`define OPC_VBUS_WAIT_US    10
`define OPC_VBUS_WAIT_CYC   (`OPC_VBUS_WAIT_US * `OPC_CLK_MHZ)

`endif

/* File: opc_pkg.sv */
/*
 * Types shared by the port control register bank.
 * Assumes opc_regs.svh supplies the numeric constants.
 */
package opc_pkg;

	// -----------------------------------------------------------------
	// Analog front end signal groups
	// -----------------------------------------------------------------
	typedef struct packed {
		logic vbus_pu;
		logic rx_off;
		logic pump_on;
		logic vbus_dis;
		logic dp_pu;
		logic dm_pu;
		logic dp_pd;
		logic dm_pd;
	} opc_afe_ctrl_t;

	typedef struct packed {
		logic vbus_lvl;
		logic id_high;
		logic vbus_ok;
	} opc_afe_stat_t;

	typedef enum logic [1:0] {
		OPC_RESP_OKAY   = 2'h0,
		OPC_RESP_SLVERR = 2'h2
	} opc_resp_t;

endpackage : opc_pkg

/* File: opc_port_ctrl.sv */
/*
 * Control and status register bank for the on-the-go port front end,
 * reached over an AXI4-Lite slave, with a status-change interrupt.
 * Assumes front end status inputs are already synchronous to aclk.
 */
// Notes on behaviour
// - Control register at offset 0xc098; interrupt status at 0xc09c, mask at 0xc0a0.
// - Bit 13 switches the VBUS pull-up.
// - Bit 12 powers down the receiver.
// - Bit 11 turns on the charge pump.
// - Bit 10 connects the VBUS discharge resistor.
// - Bit 9 enables the D+ pull-up.
// - Bit 8 enables the D- pull-up.
// - Bit 7 enables the D+ pull-down.
// - Bit 6 enables the D- pull-down.
// - Bit 2 reads the VBUS logic level.
// - Bit 1 reads the ID pin state.
// - Bit 0 reads the VBUS-valid comparator.
`include "opc_regs.svh"
`timescale 1ns/100ps

module opc_port_ctrl (
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic [31:0]           s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [31:0]           s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	input  wire opc_pkg::opc_afe_stat_t afe_stat,
	output opc_pkg::opc_afe_ctrl_t     afe_ctrl,
	output logic                       irq
);
	import opc_pkg::*;

	// -----------------------------------------------------------------
	// Register decode helpers
	// -----------------------------------------------------------------
	// A four-state base lets the decode results travel on named wires.
	typedef enum logic [1:0] {
		SEL_CTRL,
		SEL_STAT,
		SEL_MASK,
		SEL_NONE
	} opc_sel_t;

	// Decoding is shared by the read and write paths.
	function automatic opc_sel_t opc_decode(input logic [31:0] addr);
		opc_sel_t s;
		s = SEL_NONE;
		if (addr[31:`OPC_ADDR_W] == '0) begin
			case (addr[`OPC_ADDR_W-1:0])
				`OPC_OFS_CTRL:       s = SEL_CTRL;
				`OPC_OFS_IRQ_STATUS: s = SEL_STAT;
				`OPC_OFS_IRQ_MASK:   s = SEL_MASK;
				default:             s = SEL_NONE;
			endcase
		end
		return s;
	endfunction : opc_decode

	// -----------------------------------------------------------------
	// State
	// -----------------------------------------------------------------
	logic [15:0]   ctrl;
	logic [15:0]   irq_status;
	logic [15:0]   irq_mask;
	opc_afe_stat_t stat_q;
	logic          aw_held;
	logic          w_held;
	logic [31:0]   aw_addr;
	logic [31:0]   w_data;
	logic [3:0]    w_strb;

	// Write channels are held separately so they can arrive in any order.
	wire           aw_take    = s_axi_awvalid && s_axi_awready;
	wire           w_take     = s_axi_wvalid && s_axi_wready;
	wire           aw_have    = aw_held || aw_take;
	wire           w_have     = w_held || w_take;
	wire [31:0]    wr_addr    = aw_held ? aw_addr : s_axi_awaddr;
	wire [31:0]    wr_data    = w_held ? w_data : s_axi_wdata;
	wire [3:0]     wr_strb    = w_held ? w_strb : s_axi_wstrb;
	wire           wr_fire    = aw_have && w_have && !s_axi_bvalid;
	wire opc_sel_t wr_sel     = opc_decode(wr_addr);
	wire           wr_lo      = wr_strb[0];
	wire           wr_hi      = wr_strb[1];

	// Byte-lane merge; bits outside the writable mask never change.
	wire [15:0]    lane_mask  = {{8{wr_hi}}, {8{wr_lo}}};
	wire [15:0]    ctrl_bits  = lane_mask & `OPC_CTRL_MASK;
	wire [15:0]    next_ctrl  = (ctrl & ~ctrl_bits) |
	                            (wr_data[15:0] & ctrl_bits);
	wire [15:0]    next_mask  = (irq_mask & ~lane_mask) |
	                            (wr_data[15:0] & lane_mask &
	                             `OPC_IRQ_MASK_BITS);

	// Status changes on any front end line are the interrupt events.
	wire [15:0]    stat_live  = {13'h0000, stat_q};
	wire [15:0]    stat_prev;
	wire [15:0]    stat_event = stat_live ^ stat_prev;
	wire [15:0]    clr_bits   = (wr_fire && wr_sel == SEL_STAT) ?
	                            (wr_data[15:0] & lane_mask) : 16'h0000;
	wire [15:0]    next_irq   = ((irq_status & ~clr_bits) | stat_event) &
	                            `OPC_IRQ_MASK_BITS;
	logic [15:0]   stat_prev_q;
	assign stat_prev = stat_prev_q;

	// Read path: reserved bits and the upper half read as zero.
	wire           rd_fire    = s_axi_arvalid && s_axi_arready;
	wire opc_sel_t rd_sel     = opc_decode(s_axi_araddr);
	wire [15:0]    rd_ctrl    = (ctrl & `OPC_CTRL_MASK) |
	                            (stat_live & `OPC_STAT_MASK);
	wire [15:0]    rd_val     = (rd_sel == SEL_CTRL) ? rd_ctrl :
	                            (rd_sel == SEL_STAT) ? irq_status :
	                            (rd_sel == SEL_MASK) ? irq_mask :
	                            16'h0000;

	// -----------------------------------------------------------------
	// Write address and data capture
	// -----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= 32'h0000_0000;
			w_data  <= 32'h0000_0000;
			w_strb  <= 4'h0;
		end else begin
			if (aw_take) begin
				aw_addr <= s_axi_awaddr;
			end
			if (w_take) begin
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			aw_held <= aw_have && !wr_fire;
			w_held  <= w_have && !wr_fire;
		end
	end

	// Ready is offered only while nothing of that channel is waiting.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
		end else begin
			s_axi_awready <= !(aw_have && !wr_fire) && !s_axi_awready;
			s_axi_wready  <= !(w_have && !wr_fire) && !s_axi_wready;
		end
	end

	// -----------------------------------------------------------------
	// Write response
	// -----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= OPC_RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (wr_sel == SEL_NONE) ? OPC_RESP_SLVERR
			                                     : OPC_RESP_OKAY;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// -----------------------------------------------------------------
	// Control register and front end drive
	// -----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl <= `OPC_CTRL_RESET;
		end else if (wr_fire && wr_sel == SEL_CTRL) begin
			ctrl <= next_ctrl;
		end
	end

	// Outputs are registered copies so the analog pins never glitch.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			afe_ctrl <= '0;
		end else begin
			afe_ctrl.vbus_pu  <= ctrl[`OPC_BIT_VBUS_PU];
			afe_ctrl.rx_off   <= ctrl[`OPC_BIT_RX_OFF];
			afe_ctrl.pump_on  <= ctrl[`OPC_BIT_PUMP];
			afe_ctrl.vbus_dis <= ctrl[`OPC_BIT_VBUS_DIS];
			afe_ctrl.dp_pu    <= ctrl[`OPC_BIT_DP_PU];
			afe_ctrl.dm_pu    <= ctrl[`OPC_BIT_DM_PU];
			afe_ctrl.dp_pd    <= ctrl[`OPC_BIT_DP_PD];
			afe_ctrl.dm_pd    <= ctrl[`OPC_BIT_DM_PD];
		end
	end

	// -----------------------------------------------------------------
	// Status sampling and interrupt
	// -----------------------------------------------------------------
	// The first sample after reset is the baseline, so no false event.
	logic stat_primed;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stat_q      <= '0;
			stat_prev_q <= 16'h0000;
			stat_primed <= 1'b0;
		end else begin
			stat_q      <= afe_stat;
			stat_primed <= 1'b1;
			stat_prev_q <= stat_primed ? stat_live : {13'h0000, afe_stat};
		end
	end

	// Set wins over a clear arriving in the same cycle.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_status <= `OPC_IRQ_RESET;
			irq_mask   <= `OPC_IRQ_RESET;
			irq        <= 1'b0;
		end else begin
			irq_status <= stat_primed ? next_irq :
			              (irq_status & ~clr_bits);
			if (wr_fire && wr_sel == SEL_MASK) begin
				irq_mask <= next_mask;
			end
			irq <= |(irq_status & irq_mask);
		end
	end

	// -----------------------------------------------------------------
	// Read channel
	// -----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= OPC_RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready &&
			                 !rd_fire;
			if (rd_fire) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= {16'h0000, rd_val};
				s_axi_rresp  <= (rd_sel == SEL_NONE) ? OPC_RESP_SLVERR
				                                     : OPC_RESP_OKAY;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule : opc_port_ctrl

/* File: opc_chk.sv */
/* Assertion checker of the port control bank.
   Assumes it is bound to opc_port_ctrl and sees only its ports. */
`include "opc_regs.svh"
`timescale 1ns/100ps

module opc_chk (
	input wire logic                   aclk,
	input wire logic                   aresetn,
	input wire logic [31:0]            s_axi_awaddr,
	input wire logic                   s_axi_awvalid,
	input wire logic                   s_axi_awready,
	input wire logic [31:0]            s_axi_wdata,
	input wire logic [3:0]             s_axi_wstrb,
	input wire logic                   s_axi_wvalid,
	input wire logic                   s_axi_wready,
	input wire logic [1:0]             s_axi_bresp,
	input wire logic                   s_axi_bvalid,
	input wire logic                   s_axi_bready,
	input wire logic [31:0]            s_axi_araddr,
	input wire logic                   s_axi_arvalid,
	input wire logic                   s_axi_arready,
	input wire logic [31:0]            s_axi_rdata,
	input wire logic                   s_axi_rvalid,
	input wire logic                   s_axi_rready,
	input wire opc_pkg::opc_afe_stat_t afe_stat,
	input wire opc_pkg::opc_afe_ctrl_t afe_ctrl
);
	import opc_pkg::*;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// ------
	// Helpers
	// ------
	// Address of the write in flight; cycles the status has held still.
	logic [31:0] aw_q;
	logic [2:0]  age;
	wire         aw_go = s_axi_awvalid && s_axi_awready;
	wire         w_go = s_axi_wvalid && s_axi_wready;
	wire         ctl_wr = aw_go && w_go && !s_axi_bvalid
		&& s_axi_wstrb[1:0] == 2'h3
		&& s_axi_awaddr == {16'h0, `OPC_OFS_CTRL};
	wire         hit = aw_q == {16'h0, `OPC_OFS_CTRL}
		|| aw_q == {16'h0, `OPC_OFS_IRQ_STATUS}
		|| aw_q == {16'h0, `OPC_OFS_IRQ_MASK};
	always_ff @(posedge aclk) begin
		if (aw_go)
			aw_q <= s_axi_awaddr;
		if (!aresetn || $changed(afe_stat))
			age <= 3'h0;
		else if (age != 3'h7)
			age <= age + 3'h1;
	end
	// ------
	// Assertions
	// ------
	AST_RESET_CLEAR: assert property (
		$rose(aresetn) |-> afe_ctrl == 8'h00)
		else $error("control outputs not clear after reset");
	AST_CTRL_WRITE: assert property (
		ctl_wr |-> ##2 afe_ctrl == $past(s_axi_wdata[13:6], 2))
		else $error("control outputs do not follow the write");
	AST_CTRL_QUIET: assert property (
		$changed(afe_ctrl) |-> $past(w_go, 2))
		else $error("control outputs moved without a write");
	AST_STATUS_READ: assert property (
		aw_go == aw_go && s_axi_arvalid && s_axi_arready && age > 3'h3
		&& s_axi_araddr == {16'h0, `OPC_OFS_CTRL}
		|=> s_axi_rdata[2:0] == $past(afe_stat))
		else $error("status bits do not match the front end");
	AST_RESERVED_ZERO: assert property (
		s_axi_rvalid |-> s_axi_rdata[31:14] == 18'h0
		&& s_axi_rdata[5:3] == 3'h0)
		else $error("reserved bits read nonzero");
	AST_WRITE_RESP: assert property (
		s_axi_bvalid |-> s_axi_bresp == (hit ? 2'h0 : 2'h2))
		else $error("write response code wrong");
	AST_B_AFTER: assert property (
		aw_go && w_go |=> s_axi_bvalid)
		else $error("write response late");
	AST_B_HOLD: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid [*1] ##0
		$stable(s_axi_bresp))
		else $error("write response dropped early");
	AST_R_HOLD: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	COV_CTRL_WRITE: cover property (ctl_wr);
	COV_BAD_WRITE: cover property (s_axi_bvalid && !hit);
	COV_READ_WAIT: cover property (s_axi_rvalid && !s_axi_rready);
endmodule : opc_chk

bind opc_port_ctrl opc_chk u_chk (.aclk, .aresetn, .s_axi_awaddr,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
	.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .afe_stat, .afe_ctrl);

/* File: opc_afe_model.sv */
/* Behavioural front end: VBUS charge pump, discharge and ID pin.
   Assumes the bench decides whether the ID pin is grounded. */
`timescale 1ns/100ps

module opc_afe_model #(
	parameter int RISE_CYC = 40
) (
	input  wire logic                   aclk,
	input  wire opc_pkg::opc_afe_ctrl_t afe_ctrl,
	input  wire logic                   id_grounded,
	output opc_pkg::opc_afe_stat_t      afe_stat
);
	import opc_pkg::*;
	int level = 0;
	// VBUS climbs slowly under the pump; discharge or pump off drops it.
	always @(posedge aclk) begin
		if (afe_ctrl.pump_on && !afe_ctrl.vbus_dis)
			level <= (level < RISE_CYC) ? level + 1 : level;
		else
			level <= 0;
	end
	// Logic level trips long before the valid comparator does.
	assign afe_stat.vbus_lvl = level > RISE_CYC / 4;
	assign afe_stat.id_high = !id_grounded;
	assign afe_stat.vbus_ok = level >= RISE_CYC;
endmodule : opc_afe_model

/* File: opc_port_ctrl_test.sv */
/* Self-checking bench of the port control bank.
   Assumes opc_afe_model stands in for the analog front end. */
`include "opc_regs.svh"
`timescale 1ns/100ps
`define CHK(name, exp, got) \
	begin \
		check_count++; \
		if ((got) !== (exp)) begin \
			mismatches++; \
			$display("wrong value %s expected %h seen %h", name, exp, got); \
		end \
	end

module opc_port_ctrl_test;
	import opc_pkg::*;
	localparam int          RISE = 40;
	localparam logic [31:0] CTRL = {16'h0, `OPC_OFS_CTRL};
	localparam logic [31:0] IST = {16'h0, `OPC_OFS_IRQ_STATUS};
	localparam logic [31:0] IMK = {16'h0, `OPC_OFS_IRQ_MASK};
	logic                   aclk, aresetn = 1'b0, id_gnd = 1'b0;
	logic [31:0]            s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0;
	logic [31:0]            s_axi_araddr = 32'h0, s_axi_rdata, d;
	logic [31:0]            seed = 32'h4a;
	logic [3:0]             s_axi_wstrb = 4'hf;
	logic                   s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic                   s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic                   s_axi_rready = 1'b0, s_axi_awready;
	logic                   s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic                   s_axi_rvalid, irq;
	logic [1:0]             s_axi_bresp, s_axi_rresp;
	logic [33:0]            exp_q[$], exp_v;
	opc_afe_stat_t          afe_stat;
	opc_afe_ctrl_t          afe_ctrl;
	int                     mismatches = 0, check_count = 0, cyc = 0;

	opc_port_ctrl u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .afe_stat, .afe_ctrl,
		.irq);
	opc_afe_model #(.RISE_CYC(RISE)) u_afe (.aclk, .afe_ctrl,
		.id_grounded(id_gnd), .afe_stat);

	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs

	task automatic close_out();
		if (mismatches == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : close_out

	// ------
	// Bus master
	// ------
	// Each task notes its expected answer, then keeps the channel rules.
	task automatic wr(input logic [31:0] a, d, input logic [1:0] r);
		@(posedge aclk);
		exp_q.push_back({r, 32'h0});
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
	endtask : wr

	// Ready is held back one cycle so the slave must keep its answer.
	task automatic rd(input logic [31:0] a, input logic [33:0] e);
		@(posedge aclk);
		exp_q.push_back(e);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		s_axi_rready <= 1'b1;
		@(posedge aclk);
		s_axi_rready <= 1'b0;
	endtask : rd

	// ------
	// Clock, watchdog and response monitor
	// ------
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	// Only one access is in flight, so the oldest note is the right one.
	always @(posedge aclk) begin
		cyc++;
		if (s_axi_bvalid && s_axi_bready) begin
			exp_v = exp_q.pop_front();
			`CHK("bresp", exp_v, {s_axi_bresp, 32'h0})
		end
		if (s_axi_rvalid && s_axi_rready) begin
			exp_v = exp_q.pop_front();
			`CHK("read", exp_v, {s_axi_rresp, s_axi_rdata})
		end
		if (cyc == 5000) begin
			mismatches++;
			close_out();
		end
	end

	// ------
	// Scenarios
	// ------
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		rd(CTRL, {2'h0, 32'h2});
		// Random control words; reserved bits zero, pump kept off.
		for (int i = 0; i < 12; i++) begin
			seed = xs(seed);
			d = seed & 32'h37c7;
			id_gnd <= seed[20];
			wr(CTRL, d, 2'h0);
			@(posedge aclk);
			`CHK("afe_ctrl", d[13:6], afe_ctrl)
			rd(CTRL, {2'h0, d & 32'h3fc0 | {30'h0, !id_gnd, 1'b0}});
		end
		// Pump: logic level first, valid flag only after the wait.
		wr(CTRL, 32'h0800, 2'h0);
		repeat (RISE / 2) @(posedge aclk);
		rd(CTRL, {2'h0, 32'h0804 | {30'h0, !id_gnd, 1'b0}});
		repeat (RISE) @(posedge aclk);
		rd(CTRL, {2'h0, 32'h0805 | {30'h0, !id_gnd, 1'b0}});
		wr(CTRL, 32'h0c00, 2'h0);
		wr(32'h0000c0a4, 32'h3fc0, 2'h2);
		rd(32'h0000c0a4, {2'h2, 32'h0});
		rd(CTRL, {2'h0, 32'h0c00 | {30'h0, !id_gnd, 1'b0}});
		// Interrupt on an ID change: raise, mask, clear.
		wr(IST, 32'h7, 2'h0);
		wr(IMK, 32'h2, 2'h0);
		rd(IMK, {2'h0, 32'h2});
		`CHK("irq idle", 1'b0, irq)
		id_gnd <= !id_gnd;
		repeat (6) @(posedge aclk);
		`CHK("irq raised", 1'b1, irq)
		rd(IST, {2'h0, 32'h2});
		wr(IMK, 32'h0, 2'h0);
		repeat (2) @(posedge aclk);
		`CHK("irq masked", 1'b0, irq)
		wr(IST, 32'h2, 2'h0);
		wr(IMK, 32'h2, 2'h0);
		repeat (2) @(posedge aclk);
		`CHK("irq cleared", 1'b0, irq)
		// Reset in mid-run clears every control output.
		wr(CTRL, 32'h3fc0, 2'h0);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		`CHK("afe_ctrl reset", 8'h00, afe_ctrl)
		rd(CTRL, {2'h0, 30'h0, !id_gnd, 1'b0});
		close_out();
	end
endmodule : opc_port_ctrl_test
